/* hw/bit_ops_core.sv */
// bit, shift and flag execution block with its register port
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - a push copies a working register onto the stack and a pop loads one back from it.
// - io bit raise and lower force one addressed io register bit and leave the rest alone.
// - logical left shift fills bit 0 with zero, logical right shift fills bit 7 with zero.
// - left rotate through carry feeds carry into bit 0 and old bit 7 into carry.
// - right rotate through carry feeds carry into bit 7 and old bit 0 into carry.
// - arithmetic right shift moves bits down while bit 7 keeps its value.
// - nibble swap exchanges the upper and lower four bits at once.
// - generic status bit raise and lower act on the flag named by an index.
// - register bit to T copies the chosen bit of a working register into T.
// - T to register bit copies T into the chosen bit and leaves the others unchanged.
// - dedicated operations raise and lower the carry flag and the negative flag.
// - dedicated operations raise and lower the zero flag.
// - dedicated operations switch the global interrupt enable on and off.
// - dedicated operations raise and lower the sign flag and the overflow flag.
// - dedicated operations raise and lower T, and one raises the half carry flag.
module bit_ops_core
	import bit_ops_pkg::*;
#(
	parameter int STK_DEPTH = STACK_DEPTH
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	// block state
	output logic [7:0] status_register_o,
	output logic [IO_COUNT*8-1:0] io_data_o,
	output logic busy_o
);

	localparam int SP_W = $clog2(STK_DEPTH + 1);
	localparam int SA_W = $clog2(STK_DEPTH);
	localparam logic [SP_W-1:0] SP_FULL = SP_W'(STK_DEPTH);
	localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

	// ==========================================================
	// decoding helpers
	function automatic logic in_window(input logic [7:0] a, input logic [7:0] base, input int count);
		return (int'(a) >= int'(base)) && (int'(a) < int'(base) + count * 4) && (a[1:0] == 2'b00);
	endfunction

	// dedicated and generic flag operations: hit, flag index, new value
	function automatic logic [4:0] flag_op(input cmd_s c);
		case (c.op)
			OP_STATUS_BIT_RAISE: return {1'b1, c.bit_idx, 1'b1};
			OP_STATUS_BIT_LOWER: return {1'b1, c.bit_idx, 1'b0};
			OP_CARRY_RAISE: return {1'b1, 3'(FLAG_C), 1'b1};
			OP_CARRY_LOWER: return {1'b1, 3'(FLAG_C), 1'b0};
			OP_NEGATIVE_RAISE: return {1'b1, 3'(FLAG_N), 1'b1};
			OP_NEGATIVE_LOWER: return {1'b1, 3'(FLAG_N), 1'b0};
			OP_ZERO_RAISE: return {1'b1, 3'(FLAG_Z), 1'b1};
			OP_ZERO_LOWER: return {1'b1, 3'(FLAG_Z), 1'b0};
			OP_IRQ_GLOBAL_ON: return {1'b1, 3'(FLAG_I), 1'b1};
			OP_IRQ_GLOBAL_OFF: return {1'b1, 3'(FLAG_I), 1'b0};
			OP_SIGN_FLAG_RAISE: return {1'b1, 3'(FLAG_S), 1'b1};
			OP_SIGN_FLAG_LOWER: return {1'b1, 3'(FLAG_S), 1'b0};
			OP_OVERFLOW_RAISE: return {1'b1, 3'(FLAG_V), 1'b1};
			OP_OVERFLOW_LOWER: return {1'b1, 3'(FLAG_V), 1'b0};
			OP_T_FLAG_RAISE: return {1'b1, 3'(FLAG_T), 1'b1};
			OP_T_FLAG_LOWER: return {1'b1, 3'(FLAG_T), 1'b0};
			OP_HALF_CARRY_RAISE: return {1'b1, 3'(FLAG_H), 1'b1};
			default: return 5'h00;
		endcase
	endfunction

	// ==========================================================
	// state
	logic [7:0] wreg_reg [WREG_COUNT];
	logic [7:0] io_reg [IO_COUNT];
	logic [7:0] status_register_reg;
	logic [SP_W-1:0] sp_reg;
	logic stk_err_reg;
	state_e state_reg;
	logic [4:0] pop_idx_reg;
	logic [DATA_W-1:0] rdata_reg;

	cmd_s cmd_w;
	logic fire_w;
	logic [7:0] opnd_w;
	logic [4:0] flag_w;
	logic push_ok_w;
	logic pop_ok_w;
	logic [7:0] pop_data_w;
	shift_res_s shift_w;
	logic wreg_hit_w;
	logic io_hit_w;

	// a command written while a pop finishes is dropped, busy_o warns software
	assign cmd_w = '{
		io_idx: wdata_i[CMD_IO_LSB +: 5],
		bit_idx: wdata_i[CMD_BIT_LSB +: 3],
		reg_idx: wdata_i[CMD_REG_LSB +: 5],
		op: op_e'(wdata_i[CMD_OP_LSB +: 5])
	};
	assign fire_w = wr_i && (addr_i == CMD_OFS) && (state_reg == ST_IDLE);
	assign opnd_w = wreg_reg[cmd_w.reg_idx];
	assign flag_w = flag_op(cmd_w);
	assign push_ok_w = fire_w && (cmd_w.op == OP_PUSH) && (sp_reg != SP_FULL);
	assign pop_ok_w = fire_w && (cmd_w.op == OP_POP) && (sp_reg != '0);
	assign wreg_hit_w = in_window(addr_i, WREG_BASE, WREG_COUNT);
	assign io_hit_w = in_window(addr_i, IO_BASE, IO_COUNT);

	shift_unit u_shift (
		.op_i(cmd_w.op),
		.opnd_i(opnd_w),
		.carry_i(status_register_reg[FLAG_C]),
		.res_o(shift_w)
	);

	stack_mem #(
		.WIDTH(8),
		.DEPTH(STK_DEPTH)
	) u_stack (
		.mclk_i(mclk_i),
		.we_i(push_ok_w),
		.waddr_i(sp_reg[SA_W-1:0]),
		.wdata_i(opnd_w),
		.raddr_i(SA_W'(sp_reg - SP_ONE)),
		.rdata_o(pop_data_w)
	);

	// ==========================================================
	// sequencer: only a pop takes a second cycle
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			pop_idx_reg <= 5'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (pop_ok_w) begin
						state_reg <= ST_POP;
						pop_idx_reg <= cmd_w.reg_idx;
					end
				end
				ST_POP: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// stack pointer and error flag
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sp_reg <= '0;
			stk_err_reg <= 1'b0;
		end else begin
			if (push_ok_w) begin
				sp_reg <= sp_reg + SP_ONE;
			end else if (pop_ok_w) begin
				sp_reg <= sp_reg - SP_ONE;
			end
			// refused push or pop sets the error; the set beats a clear
			if (fire_w && ((cmd_w.op == OP_PUSH && !push_ok_w) || (cmd_w.op == OP_POP && !pop_ok_w))) begin
				stk_err_reg <= 1'b1;
			end else if (wr_i && addr_i == STACK_OFS && wdata_i[STK_ERR_BIT]) begin
				stk_err_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// working registers
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			for (int i = 0; i < WREG_COUNT; i++) begin
				wreg_reg[i] <= WREG_RST;
			end
		end else if (state_reg == ST_POP) begin
			wreg_reg[pop_idx_reg] <= pop_data_w;
		end else if (fire_w) begin
			case (cmd_w.op)
				OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
				OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH, OP_NIBBLE_SWAP: begin
					wreg_reg[cmd_w.reg_idx] <= shift_w.value;
				end
				OP_T_TO_REG_BIT: begin
					wreg_reg[cmd_w.reg_idx][cmd_w.bit_idx] <= status_register_reg[FLAG_T];
				end
				default: begin
				end
			endcase
		end else if (wr_i && wreg_hit_w) begin
			wreg_reg[addr_i[6:2]] <= wdata_i[7:0];
		end
	end

	// ==========================================================
	// io registers
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			for (int i = 0; i < IO_COUNT; i++) begin
				io_reg[i] <= IO_RST;
			end
		end else if (fire_w && cmd_w.op == OP_IO_BIT_RAISE) begin
			io_reg[cmd_w.io_idx[2:0]][cmd_w.bit_idx] <= 1'b1;
		end else if (fire_w && cmd_w.op == OP_IO_BIT_LOWER) begin
			io_reg[cmd_w.io_idx[2:0]][cmd_w.bit_idx] <= 1'b0;
		end else if (wr_i && io_hit_w) begin
			io_reg[addr_i[4:2]] <= wdata_i[7:0];
		end
	end

	// ==========================================================
	// status register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			status_register_reg <= STATUS_RST;
		end else if (fire_w && flag_w[4]) begin
			status_register_reg[flag_w[3:1]] <= flag_w[0];
		end else if (fire_w && cmd_w.op == OP_REG_BIT_TO_T) begin
			status_register_reg[FLAG_T] <= opnd_w[cmd_w.bit_idx];
		end else if (fire_w && shift_w.carry_we) begin
			status_register_reg[FLAG_C] <= shift_w.carry;
		end else if (wr_i && addr_i == STATUS_OFS) begin
			status_register_reg <= wdata_i[7:0];
		end
	end

	// ==========================================================
	// read port, data one cycle after the strobe
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_reg <= '0;
		end else if (rd_i) begin
			rdata_reg <= '0;
			if (addr_i == STATUS_OFS) begin
				rdata_reg[7:0] <= status_register_reg;
			end else if (addr_i == STACK_OFS) begin
				rdata_reg[SP_W-1:0] <= sp_reg;
				rdata_reg[STK_BUSY_BIT] <= (state_reg != ST_IDLE);
				rdata_reg[STK_ERR_BIT] <= stk_err_reg;
			end else if (io_hit_w) begin
				rdata_reg[7:0] <= io_reg[addr_i[4:2]];
			end else if (wreg_hit_w) begin
				rdata_reg[7:0] <= wreg_reg[addr_i[6:2]];
			end
		end
	end

	assign rdata_o = rdata_reg;
	assign status_register_o = status_register_reg;
	assign busy_o = (state_reg != ST_IDLE);

	for (genvar g = 0; g < IO_COUNT; g++) begin : g_io
		assign io_data_o[g*8 +: 8] = io_reg[g];
	end

	// ==========================================================
	// checks
	property p_sll;
		@(posedge mclk_i) disable iff (rst_i)
		fire_w && cmd_w.op == OP_SHIFT_LEFT_LOGICAL |=> wreg_reg[$past(cmd_w.reg_idx)] == {$past(opnd_w[6:0]), 1'b0};
	endproperty
	a_sll: assert property (p_sll) else $error("left shift result wrong");

	property p_srl;
		@(posedge mclk_i) disable iff (rst_i)
		fire_w && cmd_w.op == OP_SHIFT_RIGHT_LOGICAL |=> wreg_reg[$past(cmd_w.reg_idx)] == {1'b0, $past(opnd_w[7:1])};
	endproperty
	a_srl: assert property (p_srl) else $error("right shift result wrong");

	property p_rol;
		@(posedge mclk_i) disable iff (rst_i)
		fire_w && cmd_w.op == OP_ROTATE_LEFT_CARRY |=> status_register_reg[FLAG_C] == $past(opnd_w[7])
			&& wreg_reg[$past(cmd_w.reg_idx)][0] == $past(status_register_reg[FLAG_C]);
	endproperty
	a_rol: assert property (p_rol) else $error("left rotate carry wrong");

	property p_ror;
		@(posedge mclk_i) disable iff (rst_i)
		fire_w && cmd_w.op == OP_ROTATE_RIGHT_CARRY |=> status_register_reg[FLAG_C] == $past(opnd_w[0])
			&& wreg_reg[$past(cmd_w.reg_idx)][7] == $past(status_register_reg[FLAG_C]);
	endproperty
	a_ror: assert property (p_ror) else $error("right rotate carry wrong");

	property p_asr;
		@(posedge mclk_i) disable iff (rst_i)
		fire_w && cmd_w.op == OP_SHIFT_RIGHT_ARITH |=> wreg_reg[$past(cmd_w.reg_idx)][7:6] == {2{$past(opnd_w[7])}};
	endproperty
	a_asr: assert property (p_asr) else $error("arithmetic shift lost sign");

	property p_swap;
		@(posedge mclk_i) disable iff (rst_i)
		fire_w && cmd_w.op == OP_NIBBLE_SWAP |=> wreg_reg[$past(cmd_w.reg_idx)] == {$past(opnd_w[3:0]), $past(opnd_w[7:4])};
	endproperty
	a_swap: assert property (p_swap) else $error("nibble swap wrong");

	property p_status_bit;
		@(posedge mclk_i) disable iff (rst_i)
		fire_w && cmd_w.op == OP_STATUS_BIT_RAISE |=> status_register_reg[$past(cmd_w.bit_idx)] == 1'b1;
	endproperty
	a_status_bit: assert property (p_status_bit) else $error("indexed flag not raised");

	property p_bit_to_t;
		@(posedge mclk_i) disable iff (rst_i)
		fire_w && cmd_w.op == OP_REG_BIT_TO_T |=> status_register_reg[FLAG_T] == $past(opnd_w[cmd_w.bit_idx]);
	endproperty
	a_bit_to_t: assert property (p_bit_to_t) else $error("T copy wrong");

	property p_irq_off;
		@(posedge mclk_i) disable iff (rst_i)
		fire_w && cmd_w.op == OP_IRQ_GLOBAL_OFF |=> !status_register_o[FLAG_I] && $stable(status_register_o[6:0]);
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt enable not cleared");

	property p_pop;
		@(posedge mclk_i) disable iff (rst_i)
		pop_ok_w |=> busy_o ##1 !busy_o && wreg_reg[$past(pop_idx_reg)] == $past(pop_data_w);
	endproperty
	a_pop: assert property (p_pop) else $error("pop did not load register");

endmodule

/* hw/bit_ops_pkg.sv */
// shared constants and types for the bit and shift execution block
package bit_ops_pkg;

	// ==========================================================
	// bus and register map
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] STACK_OFS = 8'h08;
	localparam logic [7:0] IO_BASE = 8'h40;
	localparam logic [7:0] WREG_BASE = 8'h80;
	localparam int IO_COUNT = 8;
	localparam int WREG_COUNT = 32;
	localparam int STACK_DEPTH = 16;

	// ==========================================================
	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_REG_LSB = 8;
	localparam int CMD_BIT_LSB = 16;
	localparam int CMD_IO_LSB = 24;

	// ==========================================================
	// stack control word fields
	localparam int STK_BUSY_BIT = 16;
	localparam int STK_ERR_BIT = 17;

	// ==========================================================
	// status register flag positions and reset values
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] IO_RST = 8'h00;
	localparam logic [7:0] WREG_RST = 8'h00;

	// ==========================================================
	// operations
	typedef enum logic [4:0] {
		OP_NONE = 5'h00,
		OP_PUSH = 5'h01,
		OP_POP = 5'h02,
		OP_IO_BIT_RAISE = 5'h03,
		OP_IO_BIT_LOWER = 5'h04,
		OP_SHIFT_LEFT_LOGICAL = 5'h05,
		OP_SHIFT_RIGHT_LOGICAL = 5'h06,
		OP_ROTATE_LEFT_CARRY = 5'h07,
		OP_ROTATE_RIGHT_CARRY = 5'h08,
		OP_SHIFT_RIGHT_ARITH = 5'h09,
		OP_NIBBLE_SWAP = 5'h0A,
		OP_STATUS_BIT_RAISE = 5'h0B,
		OP_STATUS_BIT_LOWER = 5'h0C,
		OP_REG_BIT_TO_T = 5'h0D,
		OP_T_TO_REG_BIT = 5'h0E,
		OP_CARRY_RAISE = 5'h0F,
		OP_CARRY_LOWER = 5'h10,
		OP_NEGATIVE_RAISE = 5'h11,
		OP_NEGATIVE_LOWER = 5'h12,
		OP_ZERO_RAISE = 5'h13,
		OP_ZERO_LOWER = 5'h14,
		OP_IRQ_GLOBAL_ON = 5'h15,
		OP_IRQ_GLOBAL_OFF = 5'h16,
		OP_SIGN_FLAG_RAISE = 5'h17,
		OP_SIGN_FLAG_LOWER = 5'h18,
		OP_OVERFLOW_RAISE = 5'h19,
		OP_OVERFLOW_LOWER = 5'h1A,
		OP_T_FLAG_RAISE = 5'h1B,
		OP_T_FLAG_LOWER = 5'h1C,
		OP_HALF_CARRY_RAISE = 5'h1D
	} op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_POP = 2'b01
	} state_e;

	typedef struct packed {
		logic [4:0] io_idx;
		logic [2:0] bit_idx;
		logic [4:0] reg_idx;
		op_e op;
	} cmd_s;

	typedef struct packed {
		logic [7:0] value;
		logic carry;
		logic carry_we;
	} shift_res_s;

endpackage

/* hw/stack_mem.sv */
// small stack memory with registered read data
`timescale 1ns/1ps
module stack_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock
	input wire logic mclk_i,
	// write port
	input wire logic we_i,
	input wire logic [$clog2(DEPTH)-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem_reg[waddr_i] <= wdata_i;
		end
	end

	// read every cycle; caller picks the cycle it needs
	always_ff @(posedge mclk_i) begin
		rdata_o <= mem_reg[raddr_i];
	end

endmodule

/* hw/shift_unit.sv */
// single-operand shift, rotate and nibble swap datapath
`timescale 1ns/1ps
module shift_unit
	import bit_ops_pkg::*;
(
	// operation and operands
	input wire op_e op_i,
	input wire logic [7:0] opnd_i,
	input wire logic carry_i,
	// result
	output shift_res_s res_o
);

	always_comb begin
		res_o.value = opnd_i;
		res_o.carry = carry_i;
		res_o.carry_we = 1'b0;
		case (op_i)
			OP_SHIFT_LEFT_LOGICAL: begin
				res_o.value = {opnd_i[6:0], 1'b0};
			end
			OP_SHIFT_RIGHT_LOGICAL: begin
				res_o.value = {1'b0, opnd_i[7:1]};
			end
			OP_ROTATE_LEFT_CARRY: begin
				res_o.value = {opnd_i[6:0], carry_i};
				res_o.carry = opnd_i[7];
				res_o.carry_we = 1'b1;
			end
			OP_ROTATE_RIGHT_CARRY: begin
				res_o.value = {carry_i, opnd_i[7:1]};
				res_o.carry = opnd_i[0];
				res_o.carry_we = 1'b1;
			end
			OP_SHIFT_RIGHT_ARITH: begin
				res_o.value = {opnd_i[7], opnd_i[7:1]};
			end
			OP_NIBBLE_SWAP: begin
				res_o.value = {opnd_i[3:0], opnd_i[7:4]};
			end
			default: begin
				res_o.value = opnd_i;
			end
		endcase
	end

endmodule

/* tb/tb_bit_ops_core.sv */
// self-checking testbench for the bit, shift and flag execution block
`timescale 1ns/1ps
module tb_bit_ops_core
	import bit_ops_pkg::*;
;
	// ==========================================================
	// stimulus and design
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [ADDR_W-1:0] addr_i = 8'h00;
	logic [DATA_W-1:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [DATA_W-1:0] rdata_o;
	logic [7:0] status_register_o;
	logic [IO_COUNT*8-1:0] io_data_o;
	logic busy_o;
	int n_errors = 0;
	int checked = 0;
	logic [31:0] rd_val;

	always #50 mclk_i = ~mclk_i;

	bit_ops_core #(.STK_DEPTH(STACK_DEPTH)) i_bit_ops_core (
		.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .status_register_o(status_register_o), .io_data_o(io_data_o), .busy_o(busy_o)
	);

	// ==========================================================
	// helpers
	task automatic close_out();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one idle cycle sits between transfers so no strobe is driven twice in a time step
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	function automatic logic [31:0] cmd(input op_e op, input logic [4:0] r, input logic [2:0] b,
		input logic [2:0] io);
		return (32'(op) << CMD_OP_LSB) | (32'(r) << CMD_REG_LSB) | (32'(b) << CMD_BIT_LSB) | (32'(io) << CMD_IO_LSB);
	endfunction

	function automatic logic [7:0] wreg(input int i);
		return WREG_BASE + 8'(4 * i);
	endfunction

	function automatic logic [7:0] ioreg(input int i);
		return IO_BASE + 8'(4 * i);
	endfunction

	// ==========================================================
	// operation table: operand and flags in, operand and flags out
	typedef struct {
		op_e op;
		logic [2:0] b;
		logic [7:0] din, sin, dout, sout;
	} row_s;

	row_s rows [0:33] = '{
		'{OP_SHIFT_LEFT_LOGICAL, 3'h0, 8'h81, 8'h00, 8'h02, 8'h00},
		'{OP_SHIFT_LEFT_LOGICAL, 3'h0, 8'h7F, 8'h01, 8'hFE, 8'h01},
		'{OP_SHIFT_RIGHT_LOGICAL, 3'h0, 8'h81, 8'h00, 8'h40, 8'h00},
		'{OP_SHIFT_RIGHT_LOGICAL, 3'h0, 8'hFE, 8'h01, 8'h7F, 8'h01},
		'{OP_ROTATE_LEFT_CARRY, 3'h0, 8'h41, 8'h01, 8'h83, 8'h00},
		'{OP_ROTATE_LEFT_CARRY, 3'h0, 8'h80, 8'h00, 8'h00, 8'h01},
		'{OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h82, 8'h01, 8'hC1, 8'h00},
		'{OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h01, 8'h00, 8'h00, 8'h01},
		'{OP_SHIFT_RIGHT_ARITH, 3'h0, 8'h85, 8'h00, 8'hC2, 8'h00},
		'{OP_SHIFT_RIGHT_ARITH, 3'h0, 8'h42, 8'h00, 8'h21, 8'h00},
		'{OP_NIBBLE_SWAP, 3'h0, 8'hA5, 8'h00, 8'h5A, 8'h00},
		'{OP_STATUS_BIT_RAISE, 3'h3, 8'h3C, 8'h00, 8'h3C, 8'h08},
		'{OP_STATUS_BIT_LOWER, 3'h6, 8'h3C, 8'hFF, 8'h3C, 8'hBF},
		'{OP_STATUS_BIT_RAISE, 3'h7, 8'h3C, 8'h00, 8'h3C, 8'h80},
		'{OP_STATUS_BIT_LOWER, 3'h0, 8'h3C, 8'hFF, 8'h3C, 8'hFE},
		'{OP_REG_BIT_TO_T, 3'h2, 8'h04, 8'h00, 8'h04, 8'h40},
		'{OP_REG_BIT_TO_T, 3'h2, 8'hFB, 8'hFF, 8'hFB, 8'hBF},
		'{OP_T_TO_REG_BIT, 3'h7, 8'h00, 8'h40, 8'h80, 8'h40},
		'{OP_T_TO_REG_BIT, 3'h0, 8'hFF, 8'h00, 8'hFE, 8'h00},
		'{OP_CARRY_RAISE, 3'h0, 8'h3C, 8'h00, 8'h3C, 8'h01},
		'{OP_CARRY_LOWER, 3'h0, 8'h3C, 8'hFF, 8'h3C, 8'hFE},
		'{OP_NEGATIVE_RAISE, 3'h0, 8'h3C, 8'h00, 8'h3C, 8'h04},
		'{OP_NEGATIVE_LOWER, 3'h0, 8'h3C, 8'hFF, 8'h3C, 8'hFB},
		'{OP_ZERO_RAISE, 3'h0, 8'h3C, 8'h00, 8'h3C, 8'h02},
		'{OP_ZERO_LOWER, 3'h0, 8'h3C, 8'hFF, 8'h3C, 8'hFD},
		'{OP_IRQ_GLOBAL_ON, 3'h0, 8'h3C, 8'h00, 8'h3C, 8'h80},
		'{OP_IRQ_GLOBAL_OFF, 3'h0, 8'h3C, 8'hFF, 8'h3C, 8'h7F},
		'{OP_SIGN_FLAG_RAISE, 3'h0, 8'h3C, 8'h00, 8'h3C, 8'h10},
		'{OP_SIGN_FLAG_LOWER, 3'h0, 8'h3C, 8'hFF, 8'h3C, 8'hEF},
		'{OP_OVERFLOW_RAISE, 3'h0, 8'h3C, 8'h00, 8'h3C, 8'h08},
		'{OP_OVERFLOW_LOWER, 3'h0, 8'h3C, 8'hFF, 8'h3C, 8'hF7},
		'{OP_T_FLAG_RAISE, 3'h0, 8'h3C, 8'h00, 8'h3C, 8'h40},
		'{OP_T_FLAG_LOWER, 3'h0, 8'h3C, 8'hFF, 8'h3C, 8'hBF},
		'{OP_HALF_CARRY_RAISE, 3'h0, 8'h3C, 8'h00, 8'h3C, 8'h20}
	};

	// ==========================================================
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_errors++;
		$display("FAIL watchdog expected end seen hang");
		close_out();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		#1;
		check("busy after reset", 32'(busy_o), 32'h0);
		check("flags after reset", 32'(status_register_o), 32'(STATUS_RST));
		check("io after reset", io_data_o[31:0], 32'h0);
		bus_rd(STACK_OFS, rd_val);
		check("stack after reset", rd_val, 32'h0);
		bus_rd(wreg(31), rd_val);
		check("wreg after reset", rd_val, 32'(WREG_RST));
		bus_rd(8'h3C, rd_val);
		check("unmapped read", rd_val, 32'h0);

		foreach (rows[i]) begin
			bus_wr(wreg(5), 32'(rows[i].din));
			bus_wr(STATUS_OFS, 32'(rows[i].sin));
			bus_wr(CMD_OFS, cmd(rows[i].op, 5'd5, rows[i].b, 3'd0));
			bus_rd(wreg(5), rd_val);
			check($sformatf("row %0d result", i), rd_val, 32'(rows[i].dout));
			check($sformatf("row %0d flags", i), 32'(status_register_o), 32'(rows[i].sout));
		end

		// an undefined operation code changes nothing
		bus_wr(CMD_OFS, cmd(op_e'(5'h1F), 5'd5, 3'd0, 3'd0));
		bus_rd(wreg(5), rd_val);
		check("undefined op result", rd_val, 32'(rows[33].dout));
		check("undefined op flags", 32'(status_register_o), 32'(rows[33].sout));

		// io bit force, including the top register and top bit
		bus_wr(ioreg(3), 32'h5A);
		bus_wr(CMD_OFS, cmd(OP_IO_BIT_RAISE, 5'd0, 3'd0, 3'd3));
		#1;
		check("io3 raise bit0", 32'(io_data_o[31:24]), 32'h5B);
		bus_wr(CMD_OFS, cmd(OP_IO_BIT_LOWER, 5'd0, 3'd6, 3'd3));
		bus_rd(ioreg(3), rd_val);
		check("io3 lower bit6", rd_val, 32'h1B);
		bus_wr(CMD_OFS, cmd(OP_IO_BIT_RAISE, 5'd0, 3'd7, 3'd7));
		#1;
		check("io7 raise bit7", 32'(io_data_o[63:56]), 32'h80);
		check("io others kept", 32'(io_data_o[55:32]), 32'h0);

		// stack: two pushes, two pops in reverse order, then a pop on empty
		bus_wr(wreg(1), 32'h11);
		bus_wr(wreg(2), 32'h22);
		bus_wr(CMD_OFS, cmd(OP_PUSH, 5'd1, 3'd0, 3'd0));
		bus_wr(CMD_OFS, cmd(OP_PUSH, 5'd2, 3'd0, 3'd0));
		bus_rd(STACK_OFS, rd_val);
		check("stack depth 2", rd_val, 32'h2);
		bus_wr(CMD_OFS, cmd(OP_POP, 5'd3, 3'd0, 3'd0));
		#1;
		check("pop busy", 32'(busy_o), 32'h1);
		@(posedge mclk_i);
		#1;
		check("pop busy end", 32'(busy_o), 32'h0);
		bus_rd(wreg(3), rd_val);
		check("pop last pushed", rd_val, 32'h22);
		bus_wr(CMD_OFS, cmd(OP_POP, 5'd4, 3'd0, 3'd0));
		bus_rd(wreg(4), rd_val);
		check("pop first pushed", rd_val, 32'h11);
		bus_wr(wreg(6), 32'h66);
		bus_wr(CMD_OFS, cmd(OP_POP, 5'd6, 3'd0, 3'd0));
		bus_rd(wreg(6), rd_val);
		check("pop empty keeps reg", rd_val, 32'h66);
		bus_rd(STACK_OFS, rd_val);
		check("pop empty error", rd_val, 32'h1 << STK_ERR_BIT);
		bus_wr(STACK_OFS, 32'h1 << STK_ERR_BIT);
		bus_rd(STACK_OFS, rd_val);
		check("error cleared", rd_val, 32'h0);

		// fill the stack, then one push too many is refused
		repeat (STACK_DEPTH) bus_wr(CMD_OFS, cmd(OP_PUSH, 5'd1, 3'd0, 3'd0));
		bus_rd(STACK_OFS, rd_val);
		check("stack full", rd_val, 32'(STACK_DEPTH));
		bus_wr(CMD_OFS, cmd(OP_PUSH, 5'd1, 3'd0, 3'd0));
		bus_rd(STACK_OFS, rd_val);
		check("push on full refused", rd_val, 32'(STACK_DEPTH) | (32'h1 << STK_ERR_BIT));

		// reset in mid-run clears the flags again
		bus_wr(STATUS_OFS, 32'hFF);
		@(posedge mclk_i);
		rst_i <= 1'b1;
		@(posedge mclk_i);
		rst_i <= 1'b0;
		#1;
		check("flags after second reset", 32'(status_register_o), 32'(STATUS_RST));
		check("io low after second reset", io_data_o[31:0], 32'h0);
		check("io high after second reset", io_data_o[63:32], 32'h0);
		check("busy after second reset", 32'(busy_o), 32'h0);
		bus_rd(STACK_OFS, rd_val);
		check("stack after second reset", rd_val, 32'h0);
		close_out();
	end
endmodule
